/* File: inc/bsx_pkg.sv */
// Package with constants and types of the bit, shift and flag executor
package bsx_pkg;
   // Status flag positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;
   // Reset values
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] RES_RST    = 8'h00;
   // Cycle counts
   localparam logic [1:0] CYC_IO_BIT = 2'h2;
   localparam logic [1:0] CYC_SINGLE = 2'h1;
   // Register offsets (bus)
   localparam logic [3:0] OFS_STATUS = 4'h0;
   localparam logic [3:0] OFS_RESULT = 4'h1;
   localparam logic [3:0] OFS_IOOUT  = 4'h2;
   localparam logic [3:0] OFS_STATE  = 4'h3;

   typedef enum logic [4:0] {
      BSX_IDLE_OP,
      BSX_IO_BIT_SET_OP,
      BSX_IO_BIT_CLEAR_OP,
      BSX_SHIFT_LEFT_LOGICAL_OP,
      BSX_SHIFT_RIGHT_LOGICAL_OP,
      BSX_ROTATE_LEFT_CARRY_OP,
      BSX_ROTATE_RIGHT_CARRY_OP,
      BSX_SHIFT_RIGHT_ARITH_OP,
      BSX_NIBBLE_SWAP_OP,
      BSX_FLAG_SET_GENERIC_OP,
      BSX_FLAG_CLEAR_GENERIC_OP,
      BSX_BIT_TO_TRANSFER_OP,
      BSX_TRANSFER_TO_BIT_OP,
      BSX_SLEEP_OP,
      BSX_WATCHDOG_RESTART_OP,
      BSX_BREAK_OP
   } bsx_op_t;
endpackage : bsx_pkg

/* File: inc/bsx_shift_if.sv */
// Interface carrying shifter operands and results
`timescale 1ns/1ps
interface bsx_shift_if;
   logic               [7:0] opnd;
   logic                     carry_in;
   bsx_pkg::bsx_op_t         op;
   logic               [7:0] res;
   logic                     c_out;
   logic                     z_out;
   logic                     n_out;
   logic                     v_out;
   modport core (output opnd, carry_in, op, input res, c_out, z_out, n_out,
                 v_out);
   modport alu  (input opnd, carry_in, op, output res, c_out, z_out, n_out,
                 v_out);
endinterface : bsx_shift_if

/* File: hw/bsx_shifter.sv */
// Combinational shifter, rotator and nibble swapper with flag results
`timescale 1ns/1ps
module bsx_shifter (
   bsx_shift_if.alu sh
);
   // ==========================================================
   // Result selection
   wire [7:0] lsl_w = {sh.opnd[6:0], 1'b0};
   wire [7:0] lsr_w = {1'b0, sh.opnd[7:1]};
   wire [7:0] rol_w = {sh.opnd[6:0], sh.carry_in};
   wire [7:0] ror_w = {sh.carry_in, sh.opnd[7:1]};
   wire [7:0] asr_w = {sh.opnd[7], sh.opnd[7:1]};
   wire [7:0] swp_w = {sh.opnd[3:0], sh.opnd[7:4]};
   wire       left_w =
      (sh.op == bsx_pkg::BSX_SHIFT_LEFT_LOGICAL_OP) ||
      (sh.op == bsx_pkg::BSX_ROTATE_LEFT_CARRY_OP);

   assign sh.res =
      (sh.op == bsx_pkg::BSX_SHIFT_LEFT_LOGICAL_OP)  ? lsl_w :
      (sh.op == bsx_pkg::BSX_SHIFT_RIGHT_LOGICAL_OP) ? lsr_w :
      (sh.op == bsx_pkg::BSX_ROTATE_LEFT_CARRY_OP)   ? rol_w :
      (sh.op == bsx_pkg::BSX_ROTATE_RIGHT_CARRY_OP)  ? ror_w :
      (sh.op == bsx_pkg::BSX_SHIFT_RIGHT_ARITH_OP)   ? asr_w :
      (sh.op == bsx_pkg::BSX_NIBBLE_SWAP_OP)         ? swp_w :
      sh.opnd;

   // Carry is the bit pushed out; V is N xor C
   assign sh.c_out = left_w ? sh.opnd[7] : sh.opnd[0];
   assign sh.z_out = (sh.res == 8'h00);
   assign sh.n_out = sh.res[7];
   assign sh.v_out = sh.res[7] ^ sh.c_out;
endmodule : bsx_shifter

/* File: hw/bsx_exec.sv */
// Execution unit for bit, shift, flag and core control instructions
`timescale 1ns/1ps
module bsx_exec (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              issue,
   input  wire bsx_pkg::bsx_op_t  op,
   input  wire logic        [7:0] opnd,
   input  wire logic        [2:0] bit_sel,
   input  wire logic        [5:0] io_addr,
   input  wire logic        [7:0] io_rdata,
   input  wire logic        [3:0] reg_addr,
   input  wire logic        [7:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic             [7:0] reg_rdata,
   output logic             [7:0] status_flags_reg,
   output logic             [7:0] result,
   output logic                   result_we,
   output logic             [5:0] io_waddr,
   output logic             [7:0] io_wdata,
   output logic                   io_we,
   output logic                   busy,
   output logic                   done,
   output logic                   sleep_req,
   output logic                   watchdog_restart,
   output logic                   debug_break
);
   // ==========================================================
   // State and registers
   typedef enum logic {BSX_ST_RUN, BSX_ST_IO_WR} bsx_state_t;
   bsx_state_t  state_r;
   logic  [7:0] flags_r;
   logic  [7:0] res_r;
   logic        res_we_r;
   logic  [5:0] io_addr_r;
   logic  [7:0] io_data_r;
   logic        io_we_r;
   logic        io_set_r;
   logic  [2:0] io_bit_r;
   logic        done_r;
   logic        sleep_r;
   logic        wdr_r;
   logic        brk_r;
   logic  [7:0] rdata_r;

   bsx_shift_if sh ();
   assign sh.opnd     = opnd;
   assign sh.carry_in = flags_r[bsx_pkg::FLAG_C];
   assign sh.op       = op;

   bsx_shifter u_shifter (
      .sh (sh)
   );

   // ==========================================================
   // Decode
   wire       take_w  = issue && (state_r == BSX_ST_RUN);
   wire [7:0] bmask_w = 8'h01 << bit_sel;
   wire       is_shift_w =
      (op == bsx_pkg::BSX_SHIFT_LEFT_LOGICAL_OP) ||
      (op == bsx_pkg::BSX_SHIFT_RIGHT_LOGICAL_OP) ||
      (op == bsx_pkg::BSX_ROTATE_LEFT_CARRY_OP) ||
      (op == bsx_pkg::BSX_ROTATE_RIGHT_CARRY_OP) ||
      (op == bsx_pkg::BSX_SHIFT_RIGHT_ARITH_OP);
   wire       is_io_w =
      (op == bsx_pkg::BSX_IO_BIT_SET_OP) ||
      (op == bsx_pkg::BSX_IO_BIT_CLEAR_OP);
   wire [7:0] shflags_w = (flags_r & ~8'h0f) |
      ({4'h0, sh.v_out, sh.n_out, sh.z_out, sh.c_out});
   wire [7:0] bld_w = (opnd & ~bmask_w) |
      (flags_r[bsx_pkg::FLAG_T] ? bmask_w : 8'h00);
   wire [7:0] bst_w = opnd[bit_sel] ?
      (flags_r | (8'h01 << bsx_pkg::FLAG_T)) :
      (flags_r & ~(8'h01 << bsx_pkg::FLAG_T));

   // Dedicated flag ops map onto the generic set/clear with bit_sel as s
   wire [7:0] flags_nxt =
      !take_w ? flags_r :
      is_shift_w ? shflags_w :
      (op == bsx_pkg::BSX_FLAG_SET_GENERIC_OP) ?
         (flags_r | bmask_w) :
      (op == bsx_pkg::BSX_FLAG_CLEAR_GENERIC_OP) ?
         (flags_r & ~bmask_w) :
      (op == bsx_pkg::BSX_BIT_TO_TRANSFER_OP) ? bst_w :
      flags_r;

   wire       res_we_nxt = take_w && (is_shift_w ||
      (op == bsx_pkg::BSX_NIBBLE_SWAP_OP) ||
      (op == bsx_pkg::BSX_TRANSFER_TO_BIT_OP));
   wire [7:0] res_nxt = (op == bsx_pkg::BSX_TRANSFER_TO_BIT_OP) ?
      bld_w : sh.res;

   // Read-modify-write of I/O: capture in first cycle, write in second
   wire [7:0] io_mod_w = io_set_r ? (io_rdata | (8'h01 << io_bit_r)) :
                                    (io_rdata & ~(8'h01 << io_bit_r));

   // Register read decode
   wire [7:0] rd_mux_w =
      (reg_addr == bsx_pkg::OFS_STATUS) ? flags_r :
      (reg_addr == bsx_pkg::OFS_RESULT) ? res_r :
      (reg_addr == bsx_pkg::OFS_IOOUT)  ? io_data_r :
      (reg_addr == bsx_pkg::OFS_STATE)  ?
         {7'h00, state_r == BSX_ST_IO_WR} : 8'h00;
   wire       sw_flag_wr_w = reg_wr && (reg_addr == bsx_pkg::OFS_STATUS);

   // ==========================================================
   // Sequential logic
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= BSX_ST_RUN;
         flags_r <= bsx_pkg::STATUS_RST;
      end else begin
         // Instruction update takes priority over software write
         if (take_w && is_io_w) begin
            state_r <= BSX_ST_IO_WR;
         end else begin
            state_r <= BSX_ST_RUN;
         end
         if (sw_flag_wr_w && !take_w) begin
            flags_r <= reg_wdata;
         end else begin
            flags_r <= flags_nxt;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         res_r    <= bsx_pkg::RES_RST;
         res_we_r <= 1'b0;
      end else begin
         res_we_r <= res_we_nxt;
         if (res_we_nxt) begin
            res_r <= res_nxt;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         io_addr_r <= 6'h00;
         io_set_r  <= 1'b0;
         io_bit_r  <= 3'h0;
         io_data_r <= 8'h00;
         io_we_r   <= 1'b0;
      end else begin
         io_we_r <= (state_r == BSX_ST_IO_WR);
         if (take_w && is_io_w) begin
            io_addr_r <= io_addr;
            io_bit_r  <= bit_sel;
            io_set_r  <= (op == bsx_pkg::BSX_IO_BIT_SET_OP);
         end
         if (state_r == BSX_ST_IO_WR) begin
            io_data_r <= io_mod_w;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_r  <= 1'b0;
         sleep_r <= 1'b0;
         wdr_r   <= 1'b0;
         brk_r   <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         done_r  <= (take_w && !is_io_w && op != bsx_pkg::BSX_BREAK_OP) ||
                    (state_r == BSX_ST_IO_WR);
         sleep_r <= take_w && (op == bsx_pkg::BSX_SLEEP_OP);
         wdr_r   <= take_w &&
                    (op == bsx_pkg::BSX_WATCHDOG_RESTART_OP);
         brk_r   <= take_w && (op == bsx_pkg::BSX_BREAK_OP);
         if (reg_rd) begin
            rdata_r <= rd_mux_w;
         end
      end
   end

   // ==========================================================
   // Outputs
   assign status_flags_reg = flags_r;
   assign result           = res_r;
   assign result_we        = res_we_r;
   assign io_waddr         = io_addr_r;
   assign io_wdata         = io_data_r;
   assign io_we            = io_we_r;
   assign busy             = (state_r == BSX_ST_IO_WR);
   assign done             = done_r;
   assign sleep_req        = sleep_r;
   assign watchdog_restart = wdr_r;
   assign debug_break      = brk_r;
   assign reg_rdata        = rdata_r;

   // ==========================================================
   // Checks
   io_two_cycle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      take_w && is_io_w |=> busy ##1 io_we && done)
      else $error("I/O bit op not two cycles");
   io_flags_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      take_w && is_io_w && !sw_flag_wr_w |=> $stable(status_flags_reg))
      else $error("I/O bit op changed flags");
   io_clear_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_r == BSX_ST_IO_WR && !io_set_r |=> !io_wdata[io_bit_r])
      else $error("Clear bit not zero");
   shl_result_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      take_w && op == bsx_pkg::BSX_SHIFT_LEFT_LOGICAL_OP |=>
      result == {$past(opnd[6:0]), 1'b0} && result_we &&
      status_flags_reg[0] == $past(opnd[7]))
      else $error("Left shift wrong");
   ror_result_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      take_w && op == bsx_pkg::BSX_ROTATE_RIGHT_CARRY_OP |=>
      result[7] == $past(flags_r[0]) && status_flags_reg[0] ==
      $past(opnd[0]))
      else $error("Rotate right wrong");
   asr_sign_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      take_w && op == bsx_pkg::BSX_SHIFT_RIGHT_ARITH_OP |=>
      result[7] == result[6])
      else $error("Arithmetic shift lost sign");
   swap_result_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      take_w && op == bsx_pkg::BSX_NIBBLE_SWAP_OP |=>
      result == {$past(opnd[3:0]), $past(opnd[7:4])})
      else $error("Swap wrong");
   bst_t_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      take_w && op == bsx_pkg::BSX_BIT_TO_TRANSFER_OP |=>
      status_flags_reg[6] == $past(opnd[bit_sel]))
      else $error("Bit store wrong");
   sleep_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      take_w && op == bsx_pkg::BSX_SLEEP_OP |=> sleep_req && done
      ##1 !sleep_req)
      else $error("Sleep pulse wrong");
   wdr_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
      take_w && op == bsx_pkg::BSX_WATCHDOG_RESTART_OP |=>
      watchdog_restart && done)
      else $error("Watchdog restart missing");
endmodule : bsx_exec

/* File: dv/tb_top.sv */
// Self-checking bench for the bit, shift and flag executor
`timescale 1ns/1ps
module tb_top;
   // ===========================================
   // Signals and design
   logic                     ref_clk = 1'b0;
   logic                     rst_n = 1'b0;
   logic                     issue = 1'b0;
   bsx_pkg::bsx_op_t         op = bsx_pkg::BSX_IDLE_OP;
   logic               [7:0] opnd = 8'h00;
   logic               [2:0] bit_sel = 3'h0;
   logic               [5:0] io_addr = 6'h00;
   logic               [7:0] io_rdata = 8'h00;
   logic               [3:0] reg_addr = 4'h0;
   logic               [7:0] reg_wdata = 8'h00;
   logic                     reg_wr = 1'b0;
   logic                     reg_rd = 1'b0;
   logic               [7:0] reg_rdata, status_flags_reg, result, io_wdata;
   logic               [5:0] io_waddr;
   logic                     result_we, io_we, busy, done;
   logic                     sleep_req, watchdog_restart, debug_break;
   logic               [7:0] flags_m = 8'h00;
   int                       miscompares = 0;
   int                       cmp_count = 0;
   int                       ctl [4] = '{0, 13, 14, 15};

   always #2.5 ref_clk = ~ref_clk;

   bsx_exec uut (.ref_clk(ref_clk), .rst_n(rst_n), .issue(issue), .op(op),
      .opnd(opnd), .bit_sel(bit_sel), .io_addr(io_addr),
      .io_rdata(io_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .status_flags_reg(status_flags_reg), .result(result),
      .result_we(result_we), .io_waddr(io_waddr), .io_wdata(io_wdata),
      .io_we(io_we), .busy(busy), .done(done), .sleep_req(sleep_req),
      .watchdog_restart(watchdog_restart), .debug_break(debug_break));

   // ===========================================
   // Compare and report
   task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk8

   task automatic chk1(input string n, input logic e, input logic g);
      chk8(n, {7'h00, e}, {7'h00, g});
   endtask : chk1

   task automatic finish_test;
      if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   // Carry out and result of shifts and rotates
   function automatic logic [8:0] shexp(input bsx_pkg::bsx_op_t o,
                                        input logic [7:0] a, input logic c);
      case (o)
         bsx_pkg::BSX_SHIFT_LEFT_LOGICAL_OP:  return {a, 1'b0};
         bsx_pkg::BSX_SHIFT_RIGHT_LOGICAL_OP: return {a[0], 1'b0, a[7:1]};
         bsx_pkg::BSX_ROTATE_LEFT_CARRY_OP:   return {a, c};
         bsx_pkg::BSX_ROTATE_RIGHT_CARRY_OP:  return {a[0], c, a[7:1]};
         default:                             return {a[0], a[7], a[7:1]};
      endcase
   endfunction : shexp

   // ===========================================
   // Bus and instruction tasks
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk8("reg_rdata", e, reg_rdata);
   endtask : rd

   task automatic do_op(input bsx_pkg::bsx_op_t o, input logic [7:0] a,
                        input logic [2:0] b);
      logic [8:0] x;
      logic       rw;
      x = {1'b0, a};
      rw = 1'b0;
      @(posedge ref_clk);
      issue <= 1'b1;
      op <= o;
      opnd <= a;
      bit_sel <= b;
      if (o inside {[bsx_pkg::BSX_SHIFT_LEFT_LOGICAL_OP :
                     bsx_pkg::BSX_SHIFT_RIGHT_ARITH_OP]}) begin
         x = shexp(o, a, flags_m[bsx_pkg::FLAG_C]);
         flags_m[3:0] = {x[7] ^ x[8], x[7], x[7:0] == 8'h00, x[8]};
         rw = 1'b1;
      end
      case (o)
         bsx_pkg::BSX_NIBBLE_SWAP_OP: begin
            x[7:0] = {a[3:0], a[7:4]};
            rw = 1'b1;
         end
         bsx_pkg::BSX_FLAG_SET_GENERIC_OP:   rw = 1'bx;
         bsx_pkg::BSX_FLAG_CLEAR_GENERIC_OP: rw = 1'bx;
         bsx_pkg::BSX_BIT_TO_TRANSFER_OP:    rw = 1'bx;
         bsx_pkg::BSX_TRANSFER_TO_BIT_OP: begin
            x[b] = flags_m[bsx_pkg::FLAG_T];
            rw = 1'b1;
         end
         default: ;
      endcase
      if (o == bsx_pkg::BSX_FLAG_SET_GENERIC_OP) flags_m[b] = 1'b1;
      if (o == bsx_pkg::BSX_FLAG_CLEAR_GENERIC_OP) flags_m[b] = 1'b0;
      if (o == bsx_pkg::BSX_BIT_TO_TRANSFER_OP) flags_m[bsx_pkg::FLAG_T] = a[b];
      @(posedge ref_clk);
      issue <= 1'b0;
      #1;
      chk8("flags", flags_m, status_flags_reg);
      chk1("done", o != bsx_pkg::BSX_BREAK_OP, done);
      chk1("sleep_req", o == bsx_pkg::BSX_SLEEP_OP, sleep_req);
      chk1("wd_restart", o == bsx_pkg::BSX_WATCHDOG_RESTART_OP, watchdog_restart);
      chk1("debug_break", o == bsx_pkg::BSX_BREAK_OP, debug_break);
      chk1("io_we", 1'b0, io_we);
      if (rw !== 1'bx) chk1("result_we", rw, result_we);
      if (rw === 1'b1) chk8("result", x[7:0], result);
   endtask : do_op

   task automatic io_op(input logic s, input logic [5:0] p, input logic [2:0] b,
                        input logic [7:0] d);
      @(posedge ref_clk);
      issue <= 1'b1;
      op <= s ? bsx_pkg::BSX_IO_BIT_SET_OP : bsx_pkg::BSX_IO_BIT_CLEAR_OP;
      io_addr <= p;
      bit_sel <= b;
      @(posedge ref_clk);
      // Issue held while busy must be dropped
      op <= bsx_pkg::BSX_FLAG_SET_GENERIC_OP;
      bit_sel <= 3'h6;
      io_rdata <= d;
      #1;
      chk1("busy", 1'b1, busy);
      chk8("io_waddr", {2'h0, p}, {2'h0, io_waddr});
      chk1("io_we", 1'b0, io_we);
      d[b] = s;
      @(posedge ref_clk);
      issue <= 1'b0;
      io_rdata <= ~d;
      #1;
      chk1("io_we", 1'b1, io_we);
      chk1("done", 1'b1, done);
      chk8("io_wdata", d, io_wdata);
      chk8("flags", flags_m, status_flags_reg);
      @(posedge ref_clk);
      #1;
      chk1("busy", 1'b0, busy);
   endtask : io_op

   // ===========================================
   // Main sequence
   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      finish_test();
   end

   initial begin
      void'($urandom(32'h017d44ca));
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      rd(bsx_pkg::OFS_STATUS, bsx_pkg::STATUS_RST);
      for (int i = 0; i < 8; i++) do_op(bsx_pkg::BSX_FLAG_SET_GENERIC_OP, 8'h5a, 3'(i));
      for (int i = 0; i < 8; i++) do_op(bsx_pkg::BSX_FLAG_CLEAR_GENERIC_OP, 8'ha5, 3'(i));
      do_op(bsx_pkg::BSX_SHIFT_LEFT_LOGICAL_OP, 8'h81, 3'h0);
      do_op(bsx_pkg::BSX_SHIFT_RIGHT_LOGICAL_OP, 8'h01, 3'h0);
      do_op(bsx_pkg::BSX_ROTATE_RIGHT_CARRY_OP, 8'h00, 3'h0);
      do_op(bsx_pkg::BSX_ROTATE_LEFT_CARRY_OP, 8'h80, 3'h0);
      do_op(bsx_pkg::BSX_SHIFT_RIGHT_ARITH_OP, 8'h80, 3'h0);
      for (int i = 0; i < 150; i++) begin
         do_op(bsx_pkg::bsx_op_t'(5'(3 + $urandom_range(9))), 8'($urandom), 3'($urandom));
      end
      foreach (ctl[k]) do_op(bsx_pkg::bsx_op_t'(5'(ctl[k])), 8'h3c, 3'h0);
      for (int i = 0; i < 8; i++) io_op(1'(i), 6'($urandom), 3'(i), 8'($urandom));
      io_op(1'b1, 6'h3f, 3'h7, 8'h7f);
      io_op(1'b0, 6'h00, 3'h0, 8'h01);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= bsx_pkg::OFS_STATUS;
      reg_wdata <= 8'hc3;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      flags_m = 8'hc3;
      rd(bsx_pkg::OFS_STATUS, 8'hc3);
      rd(bsx_pkg::OFS_STATE, 8'h00);
      rd(4'hf, 8'h00);
      do_op(bsx_pkg::BSX_IDLE_OP, 8'hff, 3'h7);
      finish_test();
   end
endmodule : tb_top
